// >>> core/rhs_radio_dev.sv
// Radio end: serial slave, buffers and operating-state sequencer
// Notes on behaviour
// R1 - Host never lowers both selects together
// R2 - Serial clock stays at or below 5 MHz
// R3 - Drive on falling edge, sample on rising
// R4 - Address and data shift MSB first
// R5 - Direction bit, 7-bit address, then data
// R6 - Half period around register select edges
// R7 - Read turnaround: host releases, device drives later
// R8 - FIFO select lead, tail and gap timing
// R9 - FIFO write data ready before first rise
// R10 - Split 32-byte buffers or merged 64-byte
// R11 - Clear bits empty their buffer
// R12 - Restore bit replays loaded TX data
// R13 - Stay IDLE for crystal settle wait
// R14 - Calibrate then enter SLEEP
// R15 - Soft reset repeats power-up from IDLE
// R16 - Host changes state via mode switch register
// R17 - Seven states in four-bit codes
// R18 - SLEEP holds contents, rejects FIFO and writes
// R19 - Immediate moves; SLEEP to STBY waits crystal
// R20 - No RFS to TX, no TFS to RX
// R21 - 20 us from synth state, plus extras
// R22 - Switch toggles TX and RX after 350 us
// R23 - Register data phase is eight bits
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module rhs_radio_dev
  import rhs_pkg::*;
#(
  parameter int SETTLE_CYC = rhs_pkg::XTAL_SETTLE_CYC,
  parameter int START_CYC = rhs_pkg::XTAL_START_CYC,
  parameter int PLL_CYC = rhs_pkg::PLL_CAL_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  rhs_spi_if.dev BUS,
  input wire logic TX_POP,
  input wire logic RX_PUSH,
  input wire logic [7:0] RX_BYTE,
  output rhs_pkg::rhs_state_t STATE,
  output logic TRANSITION_BUSY,
  output logic [7:0] TX_BYTE,
  output logic TX_BYTE_VALID,
  output logic LOW_FREQ_OSCILLATOR_EN
);
  import rhs_pkg::*;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] f;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [6:0] addr;
    logic [7:0] dout;
    logic oe_n;
    rhs_state_t st;
    rhs_state_t tgt;
    logic busy;
    logic [CNT_W-1:0] wait_cnt;
    logic merge;
    logic role_tx;
    logic host_wr;
    logic [2:0] settle_sel;
    logic wake_en;
    logic [6:0] tx_wr;
    logic [6:0] tx_rd;
    logic [6:0] rx_wr;
    logic [6:0] rx_rd;
    logic [63:0][7:0] mem;
    logic [7:0] tx_byte;
    logic tx_vld;
    logic lfo;
  } rhs_dev_t;

  rhs_dev_t s;
  rhs_dev_t n;
  logic [3:0] fn;
  logic rise;
  logic fall;
  logic sda_in;
  logic [6:0] cap;
  logic [5:0] rx_base;
  logic [7:0] wdat;
  logic [7:0] rdat;
  logic [7:0] cmd;
  logic cmd_vld;
  logic go;
  rhs_state_t nt;
  logic [CNT_W-1:0] xs;
  logic [CNT_W-1:0] pll;
  logic [CNT_W-1:0] dly;
  logic [CNT_W-1:0] settle;
  logic fifo_ok;
  logic host_push_ok;
  logic host_pop_ok;

  // ==================== Pin capture and edge detection
  always_comb begin
    n = s;
    n.s1 = {BUS.sclk, BUS.reg_select_n, BUS.fifo_select_n, BUS.sda};
    n.s2 = s.s1;
    n.s3 = s.s2;
    fn = (s.s2 & s.s3) | (s.f & (s.s2 ^ s.s3));
    n.f = fn;
    rise = fn[3] & ~s.f[3];
    fall = ~fn[3] & s.f[3];
    sda_in = fn[0];
    n.tx_vld = 1'b0;
    // Buffer geometry follows the merge bit
    cap = s.merge ? FIFO_MERGED : FIFO_SPLIT; // R10
    rx_base = s.merge ? 6'h00 : FIFO_SPLIT[5:0]; // R10
    fifo_ok = (s.st != ST_IDLE) && (s.st != ST_SLEEP); // R18
    host_push_ok = fifo_ok && s.host_wr && (!s.merge || s.role_tx); // R10
    host_pop_ok = fifo_ok && !s.host_wr && (!s.merge || !s.role_tx) && (s.rx_rd < s.rx_wr);
    wdat = {s.sh[6:0], sda_in};
    cmd = 8'h00;
    cmd_vld = 1'b0;
    settle = CNT_W'(SETTLE_CYC) >> (3'h7 - s.settle_sel); // R13
    // Register read mux
    rdat = 8'h00;
    if (s.addr == REG_STATE) begin
      rdat = {3'h0, s.busy, s.st};
    end else if (s.addr == REG_FIFO_CTL) begin
      rdat = {5'h00, s.host_wr, s.role_tx, s.merge};
    end else if (s.addr == REG_SETTLE) begin
      rdat = {4'h0, s.wake_en, s.settle_sel};
    end
    // Select release ends any transfer and frees the line
    if (fn[2] && fn[1]) begin
      n.cnt = 4'h0;
      n.oe_n = 1'b1;
    end
    // Register transaction
    if (!fn[2]) begin
      if (rise) begin
        n.sh = wdat; // R4
        n.cnt = s.cnt + 4'h1;
        if (s.cnt == 4'h7) begin
          n.rw = s.sh[6]; // R5
          n.addr = wdat[6:0];
        end
        if (s.cnt == 4'hf && s.rw != RW_READ) begin // R23
          if (s.addr == REG_MODE) begin // Passes even in SLEEP
            cmd = wdat; // R16
            cmd_vld = 1'b1;
          end else if (fifo_ok) begin // R18
            if (s.addr == REG_FIFO_CTL) begin
              n.merge = wdat[FC_MERGE];
              n.role_tx = wdat[FC_ROLE_TX];
              n.host_wr = wdat[FC_HOST_WR];
              if (wdat[FC_CLR_TX]) begin // R11
                n.tx_wr = 7'h00;
                n.tx_rd = 7'h00;
              end
              if (wdat[FC_CLR_RX]) begin // R11
                n.rx_wr = 7'h00;
                n.rx_rd = 7'h00;
              end
              if (wdat[FC_RESTORE]) begin
                n.tx_rd = 7'h00; // R12
              end
            end else if (s.addr == REG_SETTLE) begin
              n.settle_sel = wdat[2:0];
              n.wake_en = wdat[SET_WAKE];
            end
          end
        end
      end
      if (fall && s.rw == RW_READ && s.cnt >= 4'h8) begin
        if (s.cnt == 4'h8) begin
          n.dout = rdat; // R7
          n.oe_n = 1'b0; // R3
        end else begin
          n.dout = {s.dout[6:0], 1'b0}; // R4
        end
      end
    end
    // Buffer transaction, one byte per eight clocks
    if (!fn[1]) begin
      if (s.f[1]) begin
        n.cnt = 4'h0;
        if (host_pop_ok) begin
          n.dout = s.mem[rx_base + s.rx_rd[5:0]];
          n.rx_rd = s.rx_rd + 7'h01;
          n.oe_n = 1'b0;
        end
      end
      if (rise) begin
        n.sh = wdat;
        n.cnt = {1'b0, s.cnt[2:0] + 3'h1};
        if (s.cnt == 4'h7 && host_push_ok && s.tx_wr < cap) begin
          n.mem[s.tx_wr[5:0]] = wdat;
          n.tx_wr = s.tx_wr + 7'h01;
        end
      end
      if (fall && !s.oe_n) begin
        n.dout = {s.dout[6:0], 1'b0}; // R3
      end
    end
    // Radio side of the buffers
    if (TX_POP && s.st == ST_TX && s.tx_rd < s.tx_wr && (!s.merge || s.role_tx)) begin
      n.tx_byte = s.mem[s.tx_rd[5:0]];
      n.tx_vld = 1'b1;
      n.tx_rd = s.tx_rd + 7'h01;
    end
    if (RX_PUSH && s.st == ST_RX && s.rx_wr < cap && (!s.merge || !s.role_tx)) begin
      n.mem[rx_base + s.rx_wr[5:0]] = RX_BYTE;
      n.rx_wr = s.rx_wr + 7'h01;
    end
    // ==================== Operating-state sequencer
    if (s.busy) begin
      if (s.wait_cnt == '0) begin
        n.st = s.tgt; // R14
        n.busy = 1'b0;
      end else begin
        n.wait_cnt = s.wait_cnt - 1'b1;
      end
    end
    xs = (s.st == ST_SLEEP) ? CNT_W'(START_CYC) + settle : '0; // R21
    pll = (s.st == ST_SLEEP || s.st == ST_STBY) ? CNT_W'(PLL_CYC) : '0; // R20
    go = 1'b0;
    nt = s.st;
    dly = '0;
    if (cmd_vld && !s.busy && s.st != ST_IDLE) begin
      case (cmd)
        CMD_SLEEP: begin
          go = 1'b1;
          nt = ST_SLEEP; // R19
        end
        CMD_STBY: begin
          go = 1'b1;
          nt = ST_STBY;
          dly = xs; // R19
        end
        CMD_RFS: begin
          go = 1'b1;
          nt = ST_RFS;
          dly = xs + pll;
        end
        CMD_TFS: begin
          go = 1'b1;
          nt = ST_TFS;
          dly = xs + pll;
        end
        CMD_RX: begin
          go = (s.st == ST_RFS || s.st == ST_STBY || s.st == ST_SLEEP); // R20
          nt = ST_RX;
          dly = xs + pll + CNT_W'(FS_TO_TRX_CYC); // R21
        end
        CMD_TX: begin
          go = (s.st == ST_TFS || s.st == ST_STBY || s.st == ST_SLEEP); // R20
          nt = ST_TX;
          dly = xs + pll + CNT_W'(FS_TO_TRX_CYC); // R21
        end
        CMD_SWITCH: begin
          go = (s.st == ST_RX || s.st == ST_TX); // R22
          nt = (s.st == ST_RX) ? ST_TX : ST_RX;
          dly = CNT_W'(PLL_CYC); // R22
        end
        default: begin
          go = 1'b0;
        end
      endcase
    end
    if (go) begin
      if (dly == '0) begin
        n.st = nt;
      end else begin
        n.tgt = nt;
        n.busy = 1'b1;
        n.wait_cnt = dly - 1'b1;
      end
    end
    // Soft reset wins in any state
    if (cmd_vld && cmd == CMD_SOFT_RST) begin
      n.st = ST_IDLE; // R15
      n.tgt = ST_SLEEP;
      n.busy = 1'b1;
      n.settle_sel = SETTLE_SEL_RST;
      n.wait_cnt = CNT_W'(START_CYC) + CNT_W'(SETTLE_CYC) + CNT_W'(CAL_CYC); // R13
    end
    n.lfo = (n.st == ST_SLEEP) && n.wake_en; // R18
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
      s.s1 <= 4'h6;
      s.s2 <= 4'h6;
      s.s3 <= 4'h6;
      s.f <= 4'h6;
      s.oe_n <= 1'b1;
      s.st <= ST_IDLE; // R17
      s.tgt <= ST_SLEEP;
      s.busy <= 1'b1;
      s.settle_sel <= SETTLE_SEL_RST;
      s.wait_cnt <= CNT_W'(START_CYC) + CNT_W'(SETTLE_CYC) + CNT_W'(CAL_CYC); // R13
    end else begin
      s <= n;
    end
  end

  // Outputs
  assign BUS.sda_d_o = s.dout[7];
  assign BUS.sda_d_oe_n = s.oe_n;
  assign STATE = s.st;
  assign TRANSITION_BUSY = s.busy;
  assign TX_BYTE = s.tx_byte;
  assign TX_BYTE_VALID = s.tx_vld;
  assign LOW_FREQ_OSCILLATOR_EN = s.lfo;
endmodule

// >>> core/rhs_pkg.sv
// Shared constants and types for the radio host serial link
package rhs_pkg;
  // ==================== Clock and timing
  localparam int CLK_MHZ = 100;
  localparam int SCLK_MAX_KHZ = 5000;
  localparam int SCLK_HALF_CYC = (CLK_MHZ * 1000) / (2 * SCLK_MAX_KHZ);
  localparam int FSEL_TAIL_NS = 2000;
  localparam int FSEL_TAIL_CYC = (FSEL_TAIL_NS * CLK_MHZ + 999) / 1000;
  localparam int FSEL_GAP_NS = 4000;
  localparam int FSEL_GAP_CYC = (FSEL_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam real XTAL_SETTLE_MS = 2.48;
  localparam int XTAL_SETTLE_CYC = int'(XTAL_SETTLE_MS * 1000.0 * CLK_MHZ);
  localparam int XTAL_START_US = 200;
  localparam int XTAL_START_CYC = XTAL_START_US * CLK_MHZ;
  localparam int PLL_CAL_US = 350;
  localparam int PLL_CAL_CYC = PLL_CAL_US * CLK_MHZ;
  localparam int FS_TO_TRX_US = 20;
  localparam int FS_TO_TRX_CYC = FS_TO_TRX_US * CLK_MHZ;
  localparam int CAL_US = 10;
  localparam int CAL_CYC = CAL_US * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam int TMR_W = 10;
  // ==================== Device register map (7-bit addresses)
  localparam logic [6:0] REG_MODE = 7'h00;
  localparam logic [6:0] REG_STATE = 7'h01;
  localparam logic [6:0] REG_FIFO_CTL = 7'h02;
  localparam logic [6:0] REG_SETTLE = 7'h03;
  localparam int FC_MERGE = 0;
  localparam int FC_ROLE_TX = 1;
  localparam int FC_HOST_WR = 2;
  localparam int FC_CLR_TX = 3;
  localparam int FC_CLR_RX = 4;
  localparam int FC_RESTORE = 5;
  localparam int SET_WAKE = 3;
  localparam int ST_BUSY = 4;
  localparam logic [2:0] SETTLE_SEL_RST = 3'h7;
  localparam logic RW_READ = 1'b1;
  // ==================== Mode switch commands
  localparam logic [7:0] CMD_SLEEP = 8'h01;
  localparam logic [7:0] CMD_STBY = 8'h02;
  localparam logic [7:0] CMD_RFS = 8'h04;
  localparam logic [7:0] CMD_RX = 8'h08;
  localparam logic [7:0] CMD_TFS = 8'h10;
  localparam logic [7:0] CMD_TX = 8'h20;
  localparam logic [7:0] CMD_SWITCH = 8'h40;
  localparam logic [7:0] CMD_SOFT_RST = 8'h80;
  // ==================== Buffer sizes
  localparam logic [6:0] FIFO_SPLIT = 7'h20;
  localparam logic [6:0] FIFO_MERGED = 7'h40;
  // ==================== Host register map and fields
  localparam logic [31:0] HR_CMD = 32'h0000_0000;
  localparam logic [31:0] HR_STAT = 32'h0000_0004;
  localparam logic [1:0] K_REG_WR = 2'h0;
  localparam logic [1:0] K_REG_RD = 2'h1;
  localparam logic [1:0] K_FIFO_WR = 2'h2;
  localparam logic [1:0] K_FIFO_RD = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_SLEEP = 4'b0001, ST_STBY = 4'b0010, ST_RFS = 4'b0011,
    ST_TFS = 4'b0100, ST_RX = 4'b0101, ST_TX = 4'b0110
  } rhs_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_LEAD = 3'b001, H_LOW = 3'b010, H_HIGH = 3'b011, H_TAIL = 3'b100, H_GAP = 3'b101
  } rhs_phase_t;
endpackage

// >>> core/rhs_spi_if.sv
// Serial link between host and radio, with the shared data line resolved
`timescale 1ns/1ps
interface rhs_spi_if;
  logic sclk;
  logic reg_select_n;
  logic fifo_select_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic sda;
  // Wired line with pull-up
  assign sda = !sda_h_oe_n ? sda_h_o : (!sda_d_oe_n ? sda_d_o : 1'b1);
  modport host (output sclk, output reg_select_n, output fifo_select_n, output sda_h_o, output sda_h_oe_n,
                input sda);
  modport dev (input sclk, input reg_select_n, input fifo_select_n, input sda, output sda_d_o,
               output sda_d_oe_n);
endinterface

// >>> core/rhs_mcu_host.sv
// Host end: AHB-Lite command registers driving the serial link
`timescale 1ns/1ps
module rhs_mcu_host
  import rhs_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  rhs_spi_if.host BUS
);
  import rhs_pkg::*;

  typedef struct packed {
    logic sclk;
    logic rsel_n;
    logic fsel_n;
    logic sda_o;
    logic oe_n;
    rhs_phase_t ph;
    logic [TMR_W-1:0] tmr;
    logic [4:0] bits;
    logic [15:0] sh;
    logic [7:0] rd;
    logic [1:0] kind;
    logic busy;
    logic s1;
    logic s2;
    logic s3;
    logic f;
    logic dp_wr;
    logic [31:0] hr;
  } rhs_host_t;

  rhs_host_t s;
  rhs_host_t n;
  logic fin;
  logic is_reg;

  always_comb begin
    n = s;
    // Data line sampling through three stages
    n.s1 = BUS.sda;
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.f = (s.s2 == s.s3) ? s.s3 : s.f;
    is_reg = ~s.kind[1];
    fin = (s.tmr == '0);
    n.tmr = fin ? s.tmr : s.tmr - 1'b1;
    // ==================== AHB-Lite slave, zero wait
    n.dp_wr = 1'b0;
    if (HSEL && HTRANS[1] && HREADY) begin
      n.dp_wr = HWRITE && (HADDR == HR_CMD);
      if (HADDR == HR_STAT) begin
        n.hr = {16'h0000, s.rd, 7'h00, s.busy};
      end else begin
        n.hr = 32'h0000_0000;
      end
    end
    // ==================== Serial engine
    case (s.ph)
      H_IDLE: begin
        if (s.dp_wr && !s.busy) begin
          n.busy = 1'b1;
          n.kind = HWDATA[1:0];
          n.bits = 5'h00;
          n.ph = H_LEAD;
          if (!HWDATA[1]) begin
            n.rsel_n = 1'b0;
            n.sh = {(HWDATA[1:0] == K_REG_RD), HWDATA[14:8], HWDATA[23:16]}; // R5
            n.sda_o = (HWDATA[1:0] == K_REG_RD);
            n.oe_n = 1'b0;
            n.tmr = TMR_W'(SCLK_HALF_CYC); // R6
          end else begin
            n.fsel_n = 1'b0;
            n.sh = {HWDATA[23:16], 8'h00};
            n.sda_o = HWDATA[23]; // R9
            n.oe_n = (HWDATA[1:0] != K_FIFO_WR);
            n.tmr = TMR_W'(2 * SCLK_HALF_CYC); // R8
          end
        end
      end
      H_LEAD, H_LOW: begin
        if (fin) begin
          n.sclk = 1'b1;
          n.rd = {s.rd[6:0], s.f}; // R3
          n.ph = H_HIGH;
          n.tmr = TMR_W'(SCLK_HALF_CYC);
        end
      end
      H_HIGH: begin
        if (s.kind == K_REG_RD && s.bits == 5'h07 && s.tmr == TMR_W'(SCLK_HALF_CYC / 2)) begin
          n.oe_n = 1'b1; // R7
        end
        if (fin) begin
          n.sclk = 1'b0;
          n.bits = s.bits + 5'h01;
          if (s.bits == (is_reg ? 5'h0f : 5'h07)) begin // R23
            n.ph = H_TAIL;
            n.tmr = is_reg ? TMR_W'(SCLK_HALF_CYC) : TMR_W'(FSEL_TAIL_CYC); // R8
          end else begin
            n.sh = {s.sh[14:0], 1'b0}; // R4
            n.sda_o = s.sh[14];
            n.ph = H_LOW;
            n.tmr = TMR_W'(SCLK_HALF_CYC); // R2
          end
        end
      end
      H_TAIL: begin
        if (fin) begin
          n.rsel_n = 1'b1; // R6
          n.fsel_n = 1'b1; // R1
          n.oe_n = 1'b1;
          n.ph = is_reg ? H_IDLE : H_GAP;
          n.busy = ~is_reg;
          n.tmr = TMR_W'(FSEL_GAP_CYC); // R8
        end
      end
      H_GAP: begin
        if (fin) begin
          n.ph = H_IDLE;
          n.busy = 1'b0;
        end
      end
      default: begin
        n.ph = H_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
      s.rsel_n <= 1'b1;
      s.fsel_n <= 1'b1;
      s.oe_n <= 1'b1;
      s.s1 <= 1'b1;
      s.s2 <= 1'b1;
      s.s3 <= 1'b1;
      s.f <= 1'b1;
      s.ph <= H_IDLE;
    end else begin
      s <= n;
    end
  end

  // Outputs
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = s.hr;
  assign BUS.sclk = s.sclk;
  assign BUS.reg_select_n = s.rsel_n;
  assign BUS.fifo_select_n = s.fsel_n;
  assign BUS.sda_h_o = s.sda_o;
  assign BUS.sda_h_oe_n = s.oe_n;
endmodule

// >>> testbench/rhs_link_sva.sv
// Concurrent checks on the serial link joining host and radio ends
`timescale 1ns/1ps
module rhs_link_sva
  import rhs_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic sclk,
  input wire logic reg_select_n,
  input wire logic fifo_select_n,
  input wire logic sda_h_o,
  input wire logic sda_h_oe_n,
  input wire logic sda_d_o,
  input wire logic sda_d_oe_n
);
  // ==================== Helper state
  typedef struct packed {
    logic sclk_q;
    logic [4:0] rises;
    logic [9:0] since_fall;
    logic [9:0] gap;
  } rhs_chk_t;
  rhs_chk_t chk_ff;
  rhs_chk_t nxt_chk;
  // Clock rises per frame, cycles since last fall, buffer select idle time
  always_comb begin
    nxt_chk = chk_ff;
    nxt_chk.sclk_q = sclk;
    if (reg_select_n && fifo_select_n) begin
      nxt_chk.rises = 5'h00;
    end else if (sclk && !chk_ff.sclk_q) begin
      nxt_chk.rises = chk_ff.rises + 5'h01;
    end
    if (chk_ff.sclk_q && !sclk) begin
      nxt_chk.since_fall = 10'h000;
    end else if (chk_ff.since_fall != 10'h3ff) begin
      nxt_chk.since_fall = chk_ff.since_fall + 10'h001;
    end
    if (!fifo_select_n) begin
      nxt_chk.gap = 10'h000;
    end else if (chk_ff.gap != 10'h3ff) begin
      nxt_chk.gap = chk_ff.gap + 10'h001;
    end
  end
  // Helper registers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      chk_ff <= '0;
    end else begin
      chk_ff <= nxt_chk;
    end
  end
  // ==================== Assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  chk_sel_exclusive: assert property (
    reg_select_n || fifo_select_n) else $error("both selects low");
  chk_clk_idle: assert property (
    reg_select_n && fifo_select_n |-> !sclk) else $error("serial clock runs unselected");
  chk_reg_lead: assert property (
    $fell(reg_select_n) |-> (!sclk) [*8] ##1 (!sclk) [*2]) else $error("register select lead short");
  chk_reg_tail: assert property (
    $rose(reg_select_n) |-> chk_ff.since_fall >= SCLK_HALF_CYC - 1) else $error("register select tail short");
  chk_reg_bits: assert property (
    $rose(reg_select_n) |-> chk_ff.rises == 5'h10) else $error("register frame not sixteen bits");
  chk_fifo_lead: assert property (
    $fell(fifo_select_n) |-> (!sclk) [*8] ##1 (!sclk) [*8] ##1 (!sclk) [*4]) else $error("buffer lead short");
  chk_fifo_tail: assert property (
    $rose(fifo_select_n) |-> chk_ff.since_fall >= FSEL_TAIL_CYC - 1 && chk_ff.rises == 5'h08)
    else $error("buffer tail short or bit count wrong");
  chk_fifo_gap: assert property (
    $fell(fifo_select_n) |-> chk_ff.gap >= FSEL_GAP_CYC - 1) else $error("buffer select gap short");
  chk_host_hold: assert property (
    sclk && $past(sclk) && !sda_h_oe_n && !$past(sda_h_oe_n) |-> $stable(sda_h_o))
    else $error("host data moved while clock high");
  chk_dev_hold: assert property (
    sclk && $past(sclk) && !sda_d_oe_n && !$past(sda_d_oe_n) |-> $stable(sda_d_o))
    else $error("device data moved while clock high");
  chk_no_fight: assert property (
    sda_h_oe_n || sda_d_oe_n) else $error("both ends drive the data line");
  chk_dev_turn: assert property (
    $fell(sda_d_oe_n) |-> !sclk && sda_h_oe_n) else $error("device drove before clock fall");
  // Main scenarios
  cover property ($fell(sda_d_oe_n));
  cover property ($rose(fifo_select_n));
  cover property ($rose(reg_select_n));
endmodule

// >>> testbench/rhs_tb.sv
// Bench joining host and radio ends, driven over AHB-Lite
`timescale 1ns/1ps
module tb;
  import rhs_pkg::*;
  // ==================== Signals
  localparam int T_PLL = 100;
  localparam int T_UP = 50 + 200 + CAL_CYC + 1;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic tx_pop = 1'b0;
  logic rx_push = 1'b0;
  logic [7:0] rx_byte = 8'h0;
  logic hreadyout, hresp, tbusy, tx_valid, lfo_en;
  logic [31:0] hrdata;
  logic [7:0] tx_byte, fcap;
  logic [15:0] cap;
  rhs_state_t state;
  int ncap, nfcap, blen, last_blen;
  int n_mismatch = 0;
  int cmp_count = 0;
  // ==================== Design, link and checker
  rhs_spi_if i_rhs_spi_if ();
  rhs_mcu_host i_rhs_mcu_host (.CLK_SYS(clk_sys), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
    .HRDATA(hrdata), .HRESP(hresp), .BUS(i_rhs_spi_if));
  rhs_radio_dev #(.SETTLE_CYC(200), .START_CYC(50), .PLL_CYC(T_PLL)) i_rhs_radio_dev (.CLK_SYS(clk_sys),
    .RST_N(rst_n), .BUS(i_rhs_spi_if), .TX_POP(tx_pop), .RX_PUSH(rx_push), .RX_BYTE(rx_byte), .STATE(state),
    .TRANSITION_BUSY(tbusy), .TX_BYTE(tx_byte), .TX_BYTE_VALID(tx_valid), .LOW_FREQ_OSCILLATOR_EN(lfo_en));
  rhs_link_sva i_rhs_link_sva (.CLK_SYS(clk_sys), .RST_N(rst_n), .sclk(i_rhs_spi_if.sclk),
    .reg_select_n(i_rhs_spi_if.reg_select_n), .fifo_select_n(i_rhs_spi_if.fifo_select_n),
    .sda_h_o(i_rhs_spi_if.sda_h_o), .sda_h_oe_n(i_rhs_spi_if.sda_h_oe_n), .sda_d_o(i_rhs_spi_if.sda_d_o),
    .sda_d_oe_n(i_rhs_spi_if.sda_d_oe_n));
  // Clock
  always #5 clk_sys = ~clk_sys;
  // Line capture at each rising serial clock
  always @(negedge i_rhs_spi_if.reg_select_n) ncap = 0;
  always @(negedge i_rhs_spi_if.fifo_select_n) nfcap = 0;
  always @(posedge i_rhs_spi_if.sclk) begin
    if (!i_rhs_spi_if.reg_select_n) begin
      cap = {cap[14:0], i_rhs_spi_if.sda};
      ncap++;
    end
    if (!i_rhs_spi_if.fifo_select_n) begin
      fcap = {fcap[6:0], i_rhs_spi_if.sda};
      nfcap++;
    end
  end
  // Length of each timed transition
  always @(posedge clk_sys) begin
    if (tbusy === 1'b1) begin
      blen <= blen + 1;
    end else begin
      if (blen != 0) last_blen <= blen;
      blen <= 0;
    end
  end
  // ==================== Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic chk_rng(input int v, input int lo);
    chk(v >= lo && v <= lo + 6, 1'b1);
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    r = hrdata;
  endtask
  task automatic cmd(input logic [1:0] k, input logic [6:0] a, input logic [7:0] d, output logic [7:0] res);
    logic [31:0] r;
    int n;
    ahb(1'b1, HR_CMD, {8'h00, d, 1'b0, a, 6'h00, k}, r);
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 3000) begin
      ahb(1'b0, HR_STAT, 32'h0, r);
      n++;
    end
    res = r[15:8];
  endtask
  task automatic dev_wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] res;
    cmd(K_REG_WR, a, d, res);
    chk(ncap, 16);
    chk(cap, {~RW_READ, a, d});
  endtask
  task automatic dev_rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] res;
    cmd(K_REG_RD, a, 8'h00, res);
    chk(cap[15:8], {RW_READ, a});
    chk(res, exp);
    chk(cap[7:0], exp);
  endtask
  task automatic fifo_x(input logic [1:0] k, input logic [7:0] d);
    logic [7:0] res;
    cmd(k, 7'h00, d, res);
    chk(nfcap, 8);
    chk(fcap, d);
    if (k == K_FIFO_RD) chk(res, d);
  endtask
  task automatic go(input logic [7:0] c, input rhs_state_t tgt, input int lo);
    int n;
    dev_wr(REG_MODE, c);
    n = 0;
    while (state !== tgt && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    chk({28'h0, state}, {28'h0, tgt});
    repeat (2) @(posedge clk_sys);
    if (lo > 0) chk_rng(last_blen, lo);
  endtask
  task automatic refuse(input logic [7:0] c, input rhs_state_t keep);
    dev_wr(REG_MODE, c);
    repeat (FS_TO_TRX_CYC + 10) @(posedge clk_sys);
    chk({28'h0, state}, {28'h0, keep});
  endtask
  task automatic pop(input logic [7:0] exp, input logic v);
    @(posedge clk_sys);
    tx_pop <= 1'b1;
    @(posedge clk_sys);
    tx_pop <= 1'b0;
    #1;
    chk(tx_valid, v);
    if (v) chk(tx_byte, exp);
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge clk_sys);
    rx_push <= 1'b1;
    rx_byte <= b;
    @(posedge clk_sys);
    rx_push <= 1'b0;
  endtask
  task automatic up_wait(input int lo);
    int n;
    n = 0;
    while (state === ST_IDLE && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    chk_rng(n, lo);
    chk({28'h0, state}, {28'h0, ST_SLEEP});
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==================== Watchdog
  initial begin
    repeat (95000) @(posedge clk_sys);
    n_mismatch++;
    $display("unexpected at %0t got %h exp %h", $time, 32'h0, 32'h1);
    tally_and_finish();
  end
  // ==================== Test sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    chk({27'h0, i_rhs_spi_if.sclk, i_rhs_spi_if.reg_select_n, i_rhs_spi_if.fifo_select_n, tbusy, hresp}, 32'he);
    chk(hrdata, 32'h0);
    chk({28'h0, state}, 32'h0);
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    up_wait(T_UP - 3);
    dev_rd(REG_STATE, 8'h01);
    dev_wr(REG_SETTLE, 8'h0b);
    dev_rd(REG_SETTLE, {5'h00, SETTLE_SEL_RST});
    chk(lfo_en, 1'b0);
    $display("test power_up_sleep done");
    go(CMD_STBY, ST_STBY, T_UP - CAL_CYC - 3);
    dev_wr(REG_SETTLE, 8'h0b);
    dev_rd(REG_SETTLE, 8'h0b);
    dev_rd(REG_STATE, 8'h02);
    dev_wr(REG_FIFO_CTL, 8'h04);
    for (int i = 0; i < 3; i++) fifo_x(K_FIFO_WR, 8'ha0 + 8'(i));
    go(CMD_TFS, ST_TFS, T_PLL - 2);
    go(CMD_TX, ST_TX, FS_TO_TRX_CYC - 2);
    for (int i = 0; i < 3; i++) pop(8'ha0 + 8'(i), 1'b1);
    dev_wr(REG_FIFO_CTL, 8'h24);
    pop(8'ha0, 1'b1);
    dev_wr(REG_FIFO_CTL, 8'h0c);
    pop(8'h00, 1'b0);
    dev_wr(REG_FIFO_CTL, 8'h07);
    fifo_x(K_FIFO_WR, 8'h3c);
    pop(8'h3c, 1'b1);
    dev_wr(REG_FIFO_CTL, 8'h0c);
    $display("test tx_buffer done");
    go(CMD_SWITCH, ST_RX, T_PLL - 2);
    for (int i = 0; i < 34; i++) push(8'h40 + 8'(i));
    dev_wr(REG_FIFO_CTL, 8'h00);
    for (int i = 0; i < 32; i++) fifo_x(K_FIFO_RD, 8'h40 + 8'(i));
    dev_wr(REG_FIFO_CTL, 8'h10);
    push(8'h5a);
    fifo_x(K_FIFO_RD, 8'h5a);
    $display("test rx_buffer done");
    go(CMD_SWITCH, ST_TX, T_PLL - 2);
    refuse(CMD_RX, ST_TX);
    go(CMD_STBY, ST_STBY, 0);
    go(CMD_RFS, ST_RFS, T_PLL - 2);
    refuse(CMD_TX, ST_RFS);
    go(CMD_SLEEP, ST_SLEEP, 0);
    chk(lfo_en, 1'b1);
    $display("test state_moves done");
    dev_wr(REG_MODE, CMD_SOFT_RST);
    chk({28'h0, state}, {28'h0, ST_IDLE});
    up_wait(T_UP - 22);
    dev_rd(REG_SETTLE, 8'h0f);
    $display("test soft_reset done");
    tally_and_finish();
  end
endmodule
